// ===== hdl/devctl_pkg.sv
// Constants and carrier types for the device control and link capability bank
// How it works
// - Nonfatal seen flag sets, write-one clears
// - Correctable seen flag sets, write-one clears
// - Retry enable gates retry-status answers downstream
// - Read request size field, resets to 512
// - No snoop permit hardwired zero
// - Aux power permit is read-write, resets zero
// - Phantom function enable reads zero always
// - Long tag enable reads zero always
// - Payload field stored; transmit limit fixed 128
// - Relaxed order enable reads zero
// - Unsupported report enable gates that reporting
// - Fatal report enable gates fatal messages
// - Nonfatal report enable gates nonfatal messages
// - Correctable report enable gates correctable messages
// - Port number field reads zero
// - Link capability bits 23:21 read zero
// - Link active report capable reads zero
// - Surprise down report capable reads zero
// - Fatal seen flag sets, write-one clears
package devctl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_CSR_ADDR   = 8'hC8;
    localparam logic [7:0] LINK_CAP_ADDR  = 8'hCC;

    // ------------------------------------------------------------
    // Field positions of the control and status word
    // ------------------------------------------------------------
    localparam int FATAL_SEEN_BIT     = 18;
    localparam int NONFATAL_SEEN_BIT  = 17;
    localparam int COR_SEEN_BIT       = 16;
    localparam int RETRY_EN_BIT       = 15;
    localparam int RD_SIZE_LSB        = 12;
    localparam int AUX_PERMIT_BIT     = 10;
    localparam int PAYLOAD_LSB        = 5;
    localparam int UNSUP_EN_BIT       = 3;
    localparam int FATAL_EN_BIT       = 2;
    localparam int NONFATAL_EN_BIT    = 1;
    localparam int COR_EN_BIT         = 0;

    // ------------------------------------------------------------
    // Reset values and fixed encodings
    // ------------------------------------------------------------
    localparam logic [2:0]  RD_SIZE_RST   = 3'h2;
    localparam logic [2:0]  RD_SIZE_MAX   = 3'h5;
    localparam logic [2:0]  PAYLOAD_RST   = 3'h0;
    localparam logic [2:0]  PAYLOAD_USED  = 3'h0;
    localparam logic [31:0] LINK_CAP_LOW  = 32'h0003_FFFF;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Error events from the bridge core
    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
        logic unsupported;
    } err_event_t;

    // Message requests toward the upstream link
    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
    } err_msg_t;

    // Control bits that steer the bridge
    typedef struct packed {
        logic       retry_status_permit;
        logic [2:0] read_size_code;
        logic       aux_power_permit;
        logic [2:0] payload_code_used;
        logic       no_snoop_permit;
        logic       relaxed_order_enable;
    } dev_ctl_t;

endpackage : devctl_pkg

// ===== hdl/devctl_regs.sv
// Device control/status and link capability registers on classic Wishbone
`timescale 1ns/1ps
`default_nettype none

module devctl_regs
    import devctl_pkg::*;
#(
    parameter logic [31:0] LINK_CAP_LOW_BITS = LINK_CAP_LOW
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output var  logic [31:0] dat_o,
    output var  logic        ack_o,
    input  wire err_event_t  err_i,
    input  wire logic        other_ctl_i,
    output var  err_msg_t    msg_o,
    output var  logic        unsup_report_o,
    output var  dev_ctl_t    ctl_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic       fatal_seen_flag_q, fatal_seen_flag_d;
    logic       nonfatal_seen_flag_q, nonfatal_seen_flag_d;
    logic       correctable_seen_flag_q, correctable_seen_flag_d;
    logic       retry_en_q, retry_en_d;
    logic [2:0] rd_size_q, rd_size_d;
    logic       aux_power_permit_q, aux_power_permit_d;
    logic [2:0] payload_limit_q, payload_limit_d;
    logic       unsupported_report_enable_q, unsupported_report_enable_d;
    logic       fatal_report_enable_q, fatal_report_enable_d;
    logic       nonfatal_report_enable_q, nonfatal_report_enable_d;
    logic       correctable_report_enable_q, correctable_report_enable_d;
    logic       ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    err_msg_t   msg_q, msg_d;
    logic       unsup_q, unsup_d;
    logic [31:0] csr_word;
    logic        req;
    logic        wr_csr;

    // Request taken only when no ack is pending, giving one-cycle acks
    assign req    = cyc_i && stb_i && !ack_q;
    assign wr_csr = req && we_i && (adr_i == DEV_CSR_ADDR);

    // ------------------------------------------------------------
    // Read image of the control/status word
    // ------------------------------------------------------------
    // Hardwired bits (11, 9, 8, 4) and upper bits read zero
    always_comb begin
        csr_word = 32'h0000_0000;
        csr_word[FATAL_SEEN_BIT]    = fatal_seen_flag_q;
        csr_word[NONFATAL_SEEN_BIT] = nonfatal_seen_flag_q;
        csr_word[COR_SEEN_BIT]      = correctable_seen_flag_q;
        csr_word[RETRY_EN_BIT]      = retry_en_q;
        csr_word[RD_SIZE_LSB +: 3]  = rd_size_q;
        csr_word[AUX_PERMIT_BIT]    = aux_power_permit_q;
        csr_word[PAYLOAD_LSB +: 3]  = payload_limit_q;
        csr_word[UNSUP_EN_BIT]      = unsupported_report_enable_q;
        csr_word[FATAL_EN_BIT]      = fatal_report_enable_q;
        csr_word[NONFATAL_EN_BIT]   = nonfatal_report_enable_q;
        csr_word[COR_EN_BIT]        = correctable_report_enable_q;
    end

    // ------------------------------------------------------------
    // Next-state for flags, control bits and the bus answer
    // ------------------------------------------------------------
    // Set beats clear: an error in the clearing cycle stays recorded
    always_comb begin
        fatal_seen_flag_d       = fatal_seen_flag_q;
        nonfatal_seen_flag_d    = nonfatal_seen_flag_q;
        correctable_seen_flag_d = correctable_seen_flag_q;
        retry_en_d              = retry_en_q;
        rd_size_d               = rd_size_q;
        aux_power_permit_d      = aux_power_permit_q;
        payload_limit_d         = payload_limit_q;
        unsupported_report_enable_d = unsupported_report_enable_q;
        fatal_report_enable_d       = fatal_report_enable_q;
        nonfatal_report_enable_d    = nonfatal_report_enable_q;
        correctable_report_enable_d = correctable_report_enable_q;
        if (wr_csr && sel_i[2]) begin
            if (dat_i[FATAL_SEEN_BIT]) fatal_seen_flag_d = 1'b0;
            if (dat_i[NONFATAL_SEEN_BIT]) begin
                nonfatal_seen_flag_d = 1'b0;
            end
            if (dat_i[COR_SEEN_BIT]) begin
                correctable_seen_flag_d = 1'b0;
            end
        end
        if (wr_csr && sel_i[1]) begin
            retry_en_d         = dat_i[RETRY_EN_BIT];
            rd_size_d          = dat_i[RD_SIZE_LSB +: 3];
            aux_power_permit_d = dat_i[AUX_PERMIT_BIT];
        end
        if (wr_csr && sel_i[0]) begin
            payload_limit_d             = dat_i[PAYLOAD_LSB +: 3];
            unsupported_report_enable_d = dat_i[UNSUP_EN_BIT];
            fatal_report_enable_d       = dat_i[FATAL_EN_BIT];
            nonfatal_report_enable_d    = dat_i[NONFATAL_EN_BIT];
            correctable_report_enable_d = dat_i[COR_EN_BIT];
        end
        // Detection ignores the report enables
        if (err_i.fatal) fatal_seen_flag_d = 1'b1;
        if (err_i.nonfatal) nonfatal_seen_flag_d = 1'b1;
        if (err_i.correctable) correctable_seen_flag_d = 1'b1;
        ack_d = req;
        dat_d = UNMAPPED_DATA;
        if (req && !we_i) begin
            case (adr_i)
                DEV_CSR_ADDR:  dat_d = csr_word;
                // Bits 31:19 (port number, reserved, link active and
                // surprise down) read zero; only the low part is configured
                LINK_CAP_ADDR:
                    dat_d = {13'h0000, LINK_CAP_LOW_BITS[18:0]};
                default:       dat_d = UNMAPPED_DATA;
            endcase
        end
    end

    // Message requests: one pulse per detected event, gated by enables
    always_comb begin
        msg_d.fatal       = err_i.fatal && fatal_report_enable_q
                            && other_ctl_i;
        msg_d.nonfatal    = err_i.nonfatal && nonfatal_report_enable_q
                            && other_ctl_i;
        msg_d.correctable = err_i.correctable
                            && correctable_report_enable_q
                            && other_ctl_i;
        unsup_d = err_i.unsupported
                  && unsupported_report_enable_q;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fatal_seen_flag_q           <= 1'b0;
            nonfatal_seen_flag_q        <= 1'b0;
            correctable_seen_flag_q     <= 1'b0;
            retry_en_q                  <= 1'b0;
            rd_size_q                   <= RD_SIZE_RST;
            aux_power_permit_q          <= 1'b0;
            payload_limit_q             <= PAYLOAD_RST;
            unsupported_report_enable_q <= 1'b0;
            fatal_report_enable_q       <= 1'b0;
            nonfatal_report_enable_q    <= 1'b0;
            correctable_report_enable_q <= 1'b0;
            ack_q                       <= 1'b0;
            dat_q                       <= 32'h0000_0000;
            msg_q                       <= '0;
            unsup_q                     <= 1'b0;
        end else begin
            fatal_seen_flag_q           <= fatal_seen_flag_d;
            nonfatal_seen_flag_q        <= nonfatal_seen_flag_d;
            correctable_seen_flag_q     <= correctable_seen_flag_d;
            retry_en_q                  <= retry_en_d;
            rd_size_q                   <= rd_size_d;
            aux_power_permit_q          <= aux_power_permit_d;
            payload_limit_q             <= payload_limit_d;
            unsupported_report_enable_q <= unsupported_report_enable_d;
            fatal_report_enable_q       <= fatal_report_enable_d;
            nonfatal_report_enable_q    <= nonfatal_report_enable_d;
            correctable_report_enable_q <= correctable_report_enable_d;
            ack_q                       <= ack_d;
            dat_q                       <= dat_d;
            msg_q                       <= msg_d;
            unsup_q                     <= unsup_d;
        end
    end

    // Control outputs; payload fixed at 128 bytes whatever is stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_o <= '{1'b0, RD_SIZE_RST, 1'b0, PAYLOAD_USED, 1'b0, 1'b0};
        end else begin
            ctl_o.retry_status_permit  <= retry_en_d;
            ctl_o.read_size_code       <= rd_size_d;
            ctl_o.aux_power_permit     <= aux_power_permit_d;
            ctl_o.payload_code_used    <= PAYLOAD_USED;
            ctl_o.no_snoop_permit      <= 1'b0;
            ctl_o.relaxed_order_enable <= 1'b0;
        end
    end

    assign ack_o          = ack_q;
    assign dat_o          = dat_q;
    assign msg_o          = msg_q;
    assign unsup_report_o = unsup_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Error flags: set by events, cleared by writing ones
    // ------------------------------------------------------------
    // A detected event always shows in its flag one cycle later
    a_nonfatal_set: assert property (
        err_i.nonfatal |=> nonfatal_seen_flag_q)
        else $error("nonfatal flag not set");

    a_cor_set: assert property (
        err_i.correctable |=> correctable_seen_flag_q)
        else $error("correctable flag not set");

    a_fatal_set: assert property (
        err_i.fatal |=> fatal_seen_flag_q)
        else $error("fatal flag not set");

    // A clear only counts when no event competes in that cycle
    a_nonfatal_clear: assert property (
        wr_csr && sel_i[2] && dat_i[NONFATAL_SEEN_BIT] && !err_i.nonfatal
        |=> !nonfatal_seen_flag_q)
        else $error("nonfatal flag not cleared");

    a_cor_clear: assert property (
        wr_csr && sel_i[2] && dat_i[COR_SEEN_BIT] && !err_i.correctable
        |=> !correctable_seen_flag_q)
        else $error("correctable flag not cleared");

    a_fatal_clear: assert property (
        wr_csr && sel_i[2] && dat_i[FATAL_SEEN_BIT] && !err_i.fatal
        |=> !fatal_seen_flag_q)
        else $error("fatal flag not cleared");

    // Recording must not depend on the reporting enable
    a_flag_record: assert property (
        err_i.nonfatal && !nonfatal_report_enable_q
        |=> nonfatal_seen_flag_q)
        else $error("flag missed with reporting off");

    // ------------------------------------------------------------
    // Control outputs toward the bridge
    // ------------------------------------------------------------
    // Written control bits reach the bridge at the write edge
    a_retry_write: assert property (
        wr_csr && sel_i[1]
        |=> ctl_o.retry_status_permit == $past(dat_i[RETRY_EN_BIT]))
        else $error("retry enable not applied");

    a_rdsize_write: assert property (
        wr_csr && sel_i[1] |=> rd_size_q == $past(dat_i[RD_SIZE_LSB +: 3]))
        else $error("read size not written");

    // The bridge must use the same size code that software reads back
    a_rdsize_ctl: assert property (
        ctl_o.read_size_code == rd_size_q)
        else $error("read size output differs");

    a_aux_write: assert property (
        wr_csr && sel_i[1]
        |=> ctl_o.aux_power_permit == $past(dat_i[AUX_PERMIT_BIT]))
        else $error("aux power permit not applied");

    // Features the bridge never uses stay off whatever is written
    a_no_snoop: assert property (
        ctl_o.no_snoop_permit == 1'b0)
        else $error("no snoop permit raised");

    a_relaxed_off: assert property (
        ctl_o.relaxed_order_enable == 1'b0)
        else $error("relaxed ordering raised");

    // Stored payload code is only for software; transmit stays small
    a_payload_fixed: assert property (
        ctl_o.payload_code_used == PAYLOAD_USED)
        else $error("payload limit not 128");

    // ------------------------------------------------------------
    // Read data of both registers
    // ------------------------------------------------------------
    // Hardwired control bits read zero on every control read
    a_csr_hardwired: assert property (
        ack_q && $past(adr_i) == DEV_CSR_ADDR && !$past(we_i)
        |-> dat_o[11] == 1'b0 && dat_o[9] == 1'b0 && dat_o[4] == 1'b0)
        else $error("hardwired csr bits nonzero");

    a_long_tag_zero: assert property (
        ack_q && $past(adr_i) == DEV_CSR_ADDR && !$past(we_i)
        |-> dat_o[8] == 1'b0)
        else $error("long tag enable reads one");

    // Only the configured low part of link capabilities may be nonzero
    a_linkcap_top: assert property (
        ack_q && $past(adr_i) == LINK_CAP_ADDR && !$past(we_i)
        |-> dat_o[31:19] == 13'h0000)
        else $error("link capability top bits nonzero");

    a_linkcap_resv: assert property (
        ack_q && $past(adr_i) == LINK_CAP_ADDR && !$past(we_i)
        |-> dat_o[23:21] == 3'h0)
        else $error("link capability reserved bits nonzero");

    // The bridge cannot report link state, so it must not claim to
    a_link_active: assert property (
        ack_q && $past(adr_i) == LINK_CAP_ADDR && !$past(we_i)
        |-> dat_o[20] == 1'b0)
        else $error("link active capability reads one");

    a_surprise_down: assert property (
        ack_q && $past(adr_i) == LINK_CAP_ADDR && !$past(we_i)
        |-> dat_o[19] == 1'b0)
        else $error("surprise down capability reads one");

    // Unmapped places answer with zero data
    a_unmapped_zero: assert property (
        ack_q && $past(adr_i) != DEV_CSR_ADDR
        && $past(adr_i) != LINK_CAP_ADDR
        |-> dat_o == UNMAPPED_DATA)
        else $error("unmapped read not zero");

    // Read data is only driven in the answer cycle
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    // ------------------------------------------------------------
    // Message requests and the bus answer
    // ------------------------------------------------------------
    // No message may leave without its enable and a real event
    a_msg_gate: assert property (
        msg_o.fatal |-> $past(fatal_report_enable_q) && $past(err_i.fatal))
        else $error("fatal message without enable");

    // An enabled event must not be lost on its way out
    a_fatal_msg_sent: assert property (
        err_i.fatal && fatal_report_enable_q && other_ctl_i
        |=> msg_o.fatal)
        else $error("enabled fatal message missing");

    // The other control bits veto every message as well
    a_nonfatal_msg: assert property (
        msg_o.nonfatal
        |-> $past(nonfatal_report_enable_q) && $past(other_ctl_i))
        else $error("nonfatal message without enable");

    a_cor_msg: assert property (
        msg_o.correctable
        |-> $past(correctable_report_enable_q) && $past(other_ctl_i))
        else $error("correctable message without enable");

    // Unsupported requests are reported on their own enable only
    a_unsup_gate: assert property (
        unsup_report_o
        |-> $past(unsupported_report_enable_q) && $past(err_i.unsupported))
        else $error("unsupported report without enable");

    // A held ack would let the master take one request twice
    a_ack_one: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    // ------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------
    c_flag_clear: cover property (
        wr_csr && dat_i[NONFATAL_SEEN_BIT] ##1 !nonfatal_seen_flag_q);
    c_set_wins: cover property (wr_csr && sel_i[2] && err_i.correctable);
    c_fatal_msg: cover property (msg_o.fatal);
    c_unsup_report: cover property (unsup_report_o);
    c_linkcap_read: cover property (ack_q && $past(adr_i) == LINK_CAP_ADDR);

endmodule : devctl_regs

`default_nettype wire

// ===== verif/devctl_regs_bench.sv
// Self-checking bench for the device control and link capability bank
`timescale 1ns/1ps
`default_nettype none

module devctl_regs_bench
    import devctl_pkg::*;
;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        cyc_i       = 1'b0;
    logic        stb_i       = 1'b0;
    logic        we_i        = 1'b0;
    logic [7:0]  adr_i       = 8'h00;
    logic [3:0]  sel_i       = 4'h0;
    logic [31:0] dat_i       = 32'h0000_0000;
    logic        other_ctl_i = 1'b1;
    logic [31:0] dat_o;
    logic        ack_o;
    err_event_t  err_i;
    err_msg_t    msg_o;
    logic        unsup_report_o;
    dev_ctl_t    ctl_o;
    logic [31:0] q;
    int          miscompares = 0;
    int          n_checks    = 0;

    always #25 clk_i = ~clk_i;

    devctl_regs i_devctl_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_i(err_i),
        .other_ctl_i(other_ctl_i), .msg_o(msg_o),
        .unsup_report_o(unsup_report_o), .ctl_o(ctl_o));

    err_source i_err_source (.clk_i(clk_i), .err_o(err_i), .msg_i(msg_o),
        .unsup_i(unsup_report_o));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : chk

    // Classic cycle: request held until ack is sampled high at a rising
    // edge; read data is taken there, then cyc and stb rest one cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        // Taken at the first edge, answered at the next one
        chk(32'(n), 32'h0000_0002);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hF, 32'h0000_0000);
        chk(q, exp);
    endtask : rc

    task automatic cc(input logic r, input logic [2:0] s, input logic x);
        chk(32'(ctl_o), 32'({r, s, x, 3'h0, 2'b00}));
    endtask : cc

    // Pulse events, let the message pipeline drain, compare tallies
    task automatic ev(input err_event_t e, input logic [31:0] exp);
        i_err_source.pulse(e);
        repeat (4) @(posedge clk_i);
        chk({i_err_source.n_fat, i_err_source.n_nf, i_err_source.n_cor,
             i_err_source.n_uns}, exp);
    endtask : ev

    task automatic end_sim;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        miscompares++;
        end_sim;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(DEV_CSR_ADDR, 32'h0000_2000);
        cc(1'b0, 3'h2, 1'b0);
        wb(1'b1, LINK_CAP_ADDR, 4'hF, 32'hFFFF_FFFF);
        wb(1'b0, LINK_CAP_ADDR, 4'hF, 32'h0000_0000);
        chk(q & 32'hFFF8_0000, 32'h0);
        $display("test reset finished");
        // Writable bits take ones, hardwired bits stay low
        wb(1'b1, DEV_CSR_ADDR, 4'hF, 32'hFFFF_FFFF);
        rc(DEV_CSR_ADDR, 32'h0000_F4EF);
        cc(1'b1, 3'h7, 1'b1);
        // Every size code, reserved ones too, against a moving payload code
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, DEV_CSR_ADDR, 4'hF, (32'(i) << 12) | (32'(7 - i) << 5));
            rc(DEV_CSR_ADDR, (32'(i) << 12) | (32'(7 - i) << 5));
            cc(1'b0, 3'(i), 1'b0);
        end
        wb(1'b1, DEV_CSR_ADDR, 4'h1, 32'hFFFF_FFFF);
        rc(DEV_CSR_ADDR, 32'h0000_70EF);
        $display("test access finished");
        // Reporting on, then gated by the other control bits
        ev(4'hF, 32'h0101_0101);
        rc(DEV_CSR_ADDR, 32'h0007_70EF);
        other_ctl_i <= 1'b0;
        ev(4'hE, 32'h0101_0101);
        other_ctl_i <= 1'b1;
        // Write-one clear touches only the addressed flag
        wb(1'b1, DEV_CSR_ADDR, 4'h4, 32'h0002_0000);
        rc(DEV_CSR_ADDR, 32'h0005_70EF);
        wb(1'b1, DEV_CSR_ADDR, 4'h4, 32'h0005_0000);
        rc(DEV_CSR_ADDR, 32'h0000_70EF);
        // Event and clear on the same edge: the event must win
        fork
            i_err_source.pulse(4'h2);
            begin
                @(posedge clk_i);
                wb(1'b1, DEV_CSR_ADDR, 4'h4, 32'h0007_0000);
            end
        join
        rc(DEV_CSR_ADDR, 32'h0001_70EF);
        $display("test errors finished");
        // Enables off: flags still record, no messages
        wb(1'b1, DEV_CSR_ADDR, 4'h1, 32'h0000_0000);
        ev(4'hF, 32'h0101_0201);
        rc(DEV_CSR_ADDR, 32'h0007_7000);
        // Unmapped place answers with zero and keeps nothing
        wb(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
        rc(8'h40, 32'h0000_0000);
        rc(DEV_CSR_ADDR, 32'h0007_7000);
        $display("test gating finished");
        // Mid-run reset brings flags and controls back to defaults
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(DEV_CSR_ADDR, 32'h0000_2000);
        cc(1'b0, 3'h2, 1'b0);
        $display("test second reset finished");
        end_sim;
    end
endmodule : devctl_regs_bench
`default_nettype wire

// ===== verif/err_source.sv
// Bridge core model: raises error events and counts message requests
`timescale 1ns/1ps
`default_nettype none

module err_source
    import devctl_pkg::*;
(
    input  wire logic       clk_i,
    output var  err_event_t err_o,
    input  wire err_msg_t   msg_i,
    input  wire logic       unsup_i
);
    logic [7:0] n_fat = 8'h00;
    logic [7:0] n_nf  = 8'h00;
    logic [7:0] n_cor = 8'h00;
    logic [7:0] n_uns = 8'h00;

    initial err_o = '0;

    // ------------------------------------------------------------
    // Event source
    // ------------------------------------------------------------
    // One-cycle pulse on the block's clock, as the core would give it
    task automatic pulse(input err_event_t e);
        @(posedge clk_i);
        err_o <= e;
        @(posedge clk_i);
        err_o <= '0;
    endtask : pulse

    // Message sink: counts each request pulse, so a stuck level shows
    always @(posedge clk_i) begin
        if (msg_i.fatal === 1'b1) n_fat <= n_fat + 8'h01;
        if (msg_i.nonfatal === 1'b1) n_nf <= n_nf + 8'h01;
        if (msg_i.correctable === 1'b1) n_cor <= n_cor + 8'h01;
        if (unsup_i === 1'b1) n_uns <= n_uns + 8'h01;
    end
endmodule : err_source
`default_nettype wire
